// ===== see_bus_master.sv
// bus master model: scl and its side of sda, 64 ns bit time
`timescale 1ns/1ps
module see_bus_master
(
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda
);
   localparam integer Q = 16;
   initial {o_scl, o_sda} = 2'b11;   // idle bus is high
   // start, also repeated
   task start;
      o_sda = 1'b1;
      #Q o_scl = 1'b1;
      #(2*Q) o_sda = 1'b0;
      #(2*Q) o_scl = 1'b0;
   endtask
   // stop; scl then stands still until the next frame
   task stop;
      o_sda = 1'b0;
      #Q o_scl = 1'b1;
      #(2*Q) o_sda = 1'b1;
      #(2*Q);
   endtask
   // nine clocks msb first; sda moves only in scl low
   task xfer(input [8:0] tx, output [8:0] rx);
      integer n;
      for (n = 8; n >= 0; n = n - 1)
      begin
         #Q o_sda = tx[n];
         #Q o_scl = 1'b1;
         #Q rx[n] = i_sda;
         #Q o_scl = 1'b0;
      end
   endtask
endmodule

// ===== see_consts.vh
// constants for the serial eeprom slave: layout, counts and timing
`ifndef SEE_CONSTS_VH
`define SEE_CONSTS_VH

// array geometry: 2048 bytes as 128 pages of 16
`define SEE_ADDR_W        11
`define SEE_PAGE_W        4
`define SEE_PAGE_BYTES    16
`define SEE_MEM_BYTES     2048

// device address byte fields
`define SEE_DEV_TYPE_MSB  7
`define SEE_DEV_TYPE_LSB  4
`define SEE_DEV_HI_MSB    3
`define SEE_DEV_HI_LSB    1
`define SEE_DEV_RW_BIT    0

// bit counter value of the ninth (acknowledge) clock
`define SEE_ACK_SLOT      4'h8

// erased cell content
`define SEE_ERASED_BYTE   8'hff

// self-timed program time and core clock period, both in ns
`define SEE_PROG_TIME_NS  5000000
`define SEE_CLK_PERIOD_NS 4
// longest time, so the division rounds down
`define SEE_PROG_CYCLES   ((`SEE_PROG_TIME_NS) / (`SEE_CLK_PERIOD_NS))
`define SEE_PROG_CNT_W    21

`endif

// ===== see_i2c_eeprom.v
// serial eeprom slave: two-wire protocol engine, page buffer and array
`timescale 1ns/1ps
`include "see_consts.vh"
// Functional notes
// [R1] bytes go msb first, each followed by a ninth acknowledge clock
// [R2] sample sda on scl rise, change driven sda only after scl fall
// [R3] sda fall with scl high is start, sda rise with scl high is stop
// [R4] first byte after start is device address; engage only on type match
// [R5] address byte bits 3..1 are word address bits ten..eight, bit 0 read/write
// [R6] acknowledge a matching device address, leave sda released otherwise
// [R7] word address byte follows the device address except for current reads
// [R8] master writes: start, device address with write, word address, data
// [R9] acknowledge both address bytes and data; write cycle starts at stop
// [R10] while programming ignore the bus and serve no request
// [R11] page write programs up to 16 bytes of one row in one cycle
// [R12] up to fifteen more data bytes each acknowledged; program at final stop
// [R13] page write increments only low four address bits, wrapping in page
// [R14] master should not wrap within a page, earlier bytes get overwritten
// [R15] address polls get no acknowledge while busy, acknowledge once finished
// [R16] write protect high blocks all writes, low means no protection
// [R17] write protect sampled at the committing stop only
// [R18] protected write still acknowledged, no cycle at stop, ready at once
// [R19] address counter holds last location plus one; current read uses it
// [R20] read address wraps from last byte to first byte of the array
// [R21] master nack ends a read; device releases sda
// [R22] random read: dummy write then read address; its high bits ignored
// [R23] dummy write without data or stop only loads the address counter
// [R24] master ack on a read byte increments address and sends next byte
// [R25] every location starts as all ones
// [R26] start or stop mid-byte abandons the transfer
// [R27] program time is a parameter in core clock cycles

module see_i2c_eeprom
#(
   parameter                      P_DEV_TYPE    = 4'h5,   // arbitrary type code
   parameter                      P_PROG_CYCLES = `SEE_PROG_CYCLES
)
(
   input  wire                    i_core_clk,
   input  wire                    i_rst_b,
   input  wire                    i_ce,
   input  wire                    i_scl,
   input  wire                    i_sda,
   input  wire                    i_wp,
   output reg                     o_sda_out,
   output reg                     o_sda_oe,
   output reg                     o_busy
);

   // limits of this block:
   // - each scl phase must last well over three core cycles, since scl and sda
   //   are seen through two synchroniser flops and an edge stage
   // - o_sda_out stays low; the pin is open drain and only o_sda_oe moves
   // - the write-back walks the 16 buffer slots one per cycle, so
   //   P_PROG_CYCLES must be at least 16
   // - a start inside a program cycle is dropped, so a poll that overlaps
   //   the end of the cycle gets no acknowledge; the master polls again

   // bus states, one-hot
   localparam [4:0] ST_IDLE = 5'h01;   // waiting for start
   localparam [4:0] ST_DEV  = 5'h02;   // receiving device address
   localparam [4:0] ST_WADR = 5'h04;   // receiving word address
   localparam [4:0] ST_WDAT = 5'h08;   // receiving write data
   localparam [4:0] ST_RDAT = 5'h10;   // sending read data

   // counter load value, cut to the counter width on purpose
   localparam integer               L_PROG_LAST_I = P_PROG_CYCLES - 1;
   localparam [`SEE_PROG_CNT_W-1:0] L_PROG_LAST = L_PROG_LAST_I[`SEE_PROG_CNT_W-1:0];   // [R27]

   // low nibble increment inside one page
   function [`SEE_ADDR_W-1:0] page_inc;
      input [`SEE_ADDR_W-1:0] a;
      begin
         page_inc = {a[`SEE_ADDR_W-1:`SEE_PAGE_W], a[`SEE_PAGE_W-1:0] + 4'h1};
      end
   endfunction

   // whole-array increment, wraps naturally at the top
   function [`SEE_ADDR_W-1:0] arr_inc;
      input [`SEE_ADDR_W-1:0] a;
      begin
         arr_inc = a + 11'h001;
      end
   endfunction

   // array and page buffer
   reg  [7:0]                    mem_ff [0:`SEE_MEM_BYTES-1];
   reg  [7:0]                    pbuf_ff [0:`SEE_PAGE_BYTES-1];
   reg  [`SEE_PAGE_BYTES-1:0]    pval_ff;

   // synchronisers and edge history
   reg                           scl_m_ff;
   reg                           scl_s_ff;
   reg                           scl_d_ff;
   reg                           sda_m_ff;
   reg                           sda_s_ff;
   reg                           sda_d_ff;
   reg                           wp_m_ff;
   reg                           wp_s_ff;

   // protocol state
   reg  [4:0]                    state_ff;
   reg  [3:0]                    cnt_ff;
   reg  [7:0]                    sh_ff;
   reg  [7:0]                    tx_ff;
   reg                           ack_ff;
   reg  [2:0]                    hi_ff;
   reg  [`SEE_ADDR_W-1:0]        addr_ff;
   reg  [`SEE_ADDR_W-`SEE_PAGE_W-1:0] row_ff;
   reg                           commit_ff;

   // programming engine
   reg  [`SEE_PROG_CNT_W-1:0]    prog_cnt_ff;
   reg  [4:0]                    prog_idx_ff;

   // decoded bus events and helpers
   wire                          scl_rise;
   wire                          scl_fall;
   wire                          bus_start;
   wire                          bus_stop;
   wire [7:0]                    rx_byte;
   wire                          prog_active;
   wire                          type_hit;

   // loop index for the power-on fill
   integer                       i;

   // factory content: all ones, not touched by reset since it is nonvolatile
   initial
   begin
      for (i = 0; i < `SEE_MEM_BYTES; i = i + 1)
         mem_ff[i] = `SEE_ERASED_BYTE;   // [R25]
   end

   // two-flop synchronisers plus one history stage for edge finding
   always @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         scl_m_ff <= 1'b1;
         scl_s_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_m_ff <= 1'b1;
         sda_s_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         wp_m_ff  <= 1'b0;
         wp_s_ff  <= 1'b0;
      end
      else if (i_ce)
      begin
         scl_m_ff <= i_scl;
         scl_s_ff <= scl_m_ff;
         scl_d_ff <= scl_s_ff;
         sda_m_ff <= i_sda;
         sda_s_ff <= sda_m_ff;
         sda_d_ff <= sda_s_ff;
         wp_m_ff  <= i_wp;
         wp_s_ff  <= wp_m_ff;
      end
   end

   // both lines see the same delay, so start/stop against scl stays exact
   assign scl_rise  = scl_s_ff & ~scl_d_ff;
   assign scl_fall  = ~scl_s_ff & scl_d_ff;
   assign bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;   // [R3]
   assign bus_stop  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;   // [R3]
   assign rx_byte   = {sh_ff[6:0], sda_s_ff};                       // [R1]
   // commit covers the one cycle before busy rises so no start slips in
   assign prog_active = o_busy | commit_ff;
   // type code compare on the byte as it completes
   assign type_hit  = (rx_byte[`SEE_DEV_TYPE_MSB:`SEE_DEV_TYPE_LSB] == P_DEV_TYPE);

   // protocol engine: programming first, then start/stop, then scl rising and falling edges
   always @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_ff  <= ST_IDLE;
         cnt_ff    <= 4'h0;
         sh_ff     <= 8'h00;
         tx_ff     <= 8'h00;
         ack_ff    <= 1'b0;
         hi_ff     <= 3'h0;
         addr_ff   <= 11'h000;
         row_ff    <= 7'h00;
         pval_ff   <= 16'h0000;
         commit_ff <= 1'b0;
         o_sda_out <= 1'b0;
         o_sda_oe  <= 1'b0;
      end
      else if (i_ce)
      begin
         commit_ff <= 1'b0;
         if (prog_active)
         begin
            // nothing on the bus is looked at while programming
            state_ff <= ST_IDLE;   // [R10]
            o_sda_oe <= 1'b0;      // [R15]
            ack_ff   <= 1'b0;
            cnt_ff   <= 4'h0;
         end
         else if (bus_start)
         begin
            // repeated start also drops any unfinished write data
            state_ff <= ST_DEV;    // [R26]
            cnt_ff   <= 4'h0;
            o_sda_oe <= 1'b0;
            ack_ff   <= 1'b0;
            pval_ff  <= 16'h0000;  // [R23]
         end
         else if (bus_stop)
         begin
            state_ff <= ST_IDLE;   // [R26]
            cnt_ff   <= 4'h0;
            o_sda_oe <= 1'b0;
            ack_ff   <= 1'b0;
            // only a stop after data bytes starts a cycle, and only unprotected
            if ((state_ff == ST_WDAT) && (|pval_ff) && !wp_s_ff)   // [R9] [R16] [R17]
            begin
               commit_ff <= 1'b1;  // [R12]
               row_ff    <= addr_ff[`SEE_ADDR_W-1:`SEE_PAGE_W];   // [R11]
            end
            else
               pval_ff <= 16'h0000;   // [R18]
         end
         else if (scl_rise)
         begin
            // data in on the rising edge
            if (cnt_ff == `SEE_ACK_SLOT)
            begin
               // ninth clock: only a read cares what the line shows
               cnt_ff <= 4'h0;
               if (state_ff == ST_RDAT)
               begin
                  // low here is our own address ack or the master's ack
                  if (!sda_s_ff)
                  begin
                     tx_ff   <= mem_ff[addr_ff];   // [R19] [R24]
                     addr_ff <= arr_inc(addr_ff);  // [R20]
                  end
                  else
                     state_ff <= ST_IDLE;          // [R21]
               end
            end
            else
            begin
               cnt_ff <= cnt_ff + 4'h1;
               sh_ff  <= rx_byte;   // [R2]
               if (cnt_ff == 4'h7)
               begin
                  // last bit of a byte: decide the acknowledge now
                  case (state_ff)
                     ST_DEV:
                     begin
                        ack_ff <= type_hit;   // [R4] [R6]
                        if (!type_hit)
                           state_ff <= ST_IDLE;
                        else if (rx_byte[`SEE_DEV_RW_BIT])
                        begin
                           // read ignores the high address bits; the first byte is
                           // fetched in the ninth clock, so the counter moves once
                           state_ff <= ST_RDAT;               // [R22]
                        end
                        else
                        begin
                           state_ff <= ST_WADR;               // [R7]
                           hi_ff    <= rx_byte[`SEE_DEV_HI_MSB:`SEE_DEV_HI_LSB];   // [R5]
                        end
                     end
                     ST_WADR:
                     begin
                        ack_ff   <= 1'b1;                     // [R9]
                        addr_ff  <= {hi_ff, rx_byte};         // [R7] [R23]
                        pval_ff  <= 16'h0000;
                        state_ff <= ST_WDAT;
                     end
                     ST_WDAT:
                     begin
                        // a wrapped page overwrites earlier bytes, as on the part
                        ack_ff   <= 1'b1;                     // [R12]
                        pbuf_ff[addr_ff[`SEE_PAGE_W-1:0]] <= rx_byte;   // [R11] [R14]
                        pval_ff[addr_ff[`SEE_PAGE_W-1:0]] <= 1'b1;
                        addr_ff  <= page_inc(addr_ff);        // [R13]
                     end
                     ST_RDAT:
                        ack_ff <= 1'b0;
                     default:
                        ack_ff <= 1'b0;
                  endcase
               end
            end
         end
         else if (scl_fall)
         begin
            // data out only after the falling edge
            if (cnt_ff == `SEE_ACK_SLOT)
               o_sda_oe <= ack_ff;                    // [R2] [R6]
            // read bits: pull low for a zero, release for a one
            else if (state_ff == ST_RDAT)
               o_sda_oe <= ~tx_ff[3'h7 - cnt_ff[2:0]];   // [R1]
            else
               o_sda_oe <= 1'b0;
         end
      end
   end

   // page buffer write-back sweep and self-timed busy counter
   always @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_busy      <= 1'b0;
         prog_cnt_ff <= {`SEE_PROG_CNT_W{1'b0}};
         prog_idx_ff <= 5'h10;
      end
      else if (i_ce)
      begin
         if (commit_ff)
         begin
            o_busy      <= 1'b1;   // [R10]
            prog_cnt_ff <= L_PROG_LAST;   // [R27]
            prog_idx_ff <= 5'h00;
         end
         else if (o_busy)
         begin
            // one buffer slot per cycle keeps a single write port
            if (!prog_idx_ff[4])
            begin
               if (pval_ff[prog_idx_ff[3:0]])
                  mem_ff[{row_ff, prog_idx_ff[3:0]}] <= pbuf_ff[prog_idx_ff[3:0]];   // [R11]
               prog_idx_ff <= prog_idx_ff + 5'h01;
            end
            // busy ends after exactly P_PROG_CYCLES cycles
            if (prog_cnt_ff == {`SEE_PROG_CNT_W{1'b0}})
               o_busy <= 1'b0;   // [R15]
            else
               prog_cnt_ff <= prog_cnt_ff - {{(`SEE_PROG_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

// ===== see_i2c_eeprom_asserts.sv
// pin-level assertions for the serial eeprom slave
`timescale 1ns/1ps
module see_chk
#(
   parameter P_DEV_TYPE    = 4'h5,   // arbitrary type code
   parameter P_PROG_CYCLES = 200
)
(
   input  wire i_core_clk,
   input  wire i_rst_b,
   input  wire i_ce,
   input  wire i_scl,
   input  wire i_sda,
   input  wire i_wp,
   input  wire o_sda_out,
   input  wire o_sda_oe,
   input  wire o_busy
);
   reg  [31:0] bcnt_ff;
   reg  [7:0]  since_ff;
   reg         sda_q_ff;
   wire        stop_ev  = i_scl & i_sda & ~sda_q_ff;
   wire        start_ev = i_scl & ~i_sda & sda_q_ff;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   // busy run length; cycles since a stop saturate so old stops never match
   always @(posedge i_core_clk or negedge i_rst_b)
      if (!i_rst_b)
         {bcnt_ff, since_ff, sda_q_ff} <= {32'h0, 8'hff, 1'b1};
      else
      begin
         bcnt_ff  <= o_busy ? bcnt_ff + 32'h1 : 32'h0;
         since_ff <= stop_ev ? 8'h0 : since_ff + {7'h0, since_ff != 8'hff};
         sda_q_ff <= i_sda;
      end
   // a pull begins while scl is low and stands across the next rise
   sequence s_hold;
      !i_scl ##1 o_sda_oe [*7];
   endsequence
   // stop with protect held high and no cycle running
   sequence s_prot_stop;
      stop_ev && i_wp && $past(i_wp, 4) && !o_busy;
   endsequence
   a_out_low: assert property (o_sda_out == 1'b0)
      else $error("sda value not low");
   a_ack_hold: assert property ($rose(o_sda_oe) |-> s_hold)
      else $error("sda pull began in scl high or cut short");
   a_rel_scl_low: assert property ($fell(o_sda_oe) |-> !i_scl)
      else $error("sda released in scl high");
   a_start_quiet: assert property (start_ev |-> ##4 !o_sda_oe [*8])
      else $error("sda pulled after a start");
   a_busy_mute: assert property (o_busy |-> !o_sda_oe)
      else $error("answer during program cycle");
   a_busy_len: assert property ($fell(o_busy) |-> bcnt_ff == P_PROG_CYCLES)
      else $error("program cycle length wrong");
   a_stop_commit: assert property ($rose(o_busy) |-> since_ff inside {[8'h1:8'h8]})
      else $error("program cycle without a stop");
   a_wp_block: assert property (s_prot_stop |=> !o_busy [*8])
      else $error("program cycle under protect");
endmodule
bind see_i2c_eeprom see_chk #(.P_DEV_TYPE(P_DEV_TYPE), .P_PROG_CYCLES(P_PROG_CYCLES)) i_chk
(
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_scl(i_scl),
   .i_sda(i_sda), .i_wp(i_wp), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_busy(o_busy)
);

// ===== see_i2c_eeprom_tb.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ps
module see_i2c_eeprom_tb;
   localparam [3:0] TYP = 4'h5;   // arbitrary type code
   reg         clk, rst_b, wp;
   wire        scl, sda_m, oe, busy, sout;
   wire        sda = sda_m & (oe ? sout : 1'b1);   // pull-up unless driven
   integer     error_cnt, checked, cyc, i;
   reg  [8:0]  rx;
   reg  [7:0]  got [0:1];
   reg  [18:0] rows [0:5];   // word address beside its byte
   see_i2c_eeprom #(.P_DEV_TYPE(TYP), .P_PROG_CYCLES(200)) i_dut
   (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_scl(scl), .i_sda(sda),
      .i_wp(wp), .o_sda_out(sout), .o_sda_oe(oe), .o_busy(busy)
   );
   see_bus_master i_mst (.i_sda(sda), .o_scl(scl), .o_sda(sda_m));
   // 250 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
      checked = checked + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task sendb(input [7:0] b);
      i_mst.xfer({b, 1'b1}, rx);
      chk("ack", 8'h0, {7'h0, rx[0]});
   endtask
   // write n bytes from b up, check the cycle, set protect, poll it out
   task wr(input [10:0] a, input [7:0] b, input integer n, input e, input pw);
      integer k;
      i_mst.start();
      sendb({TYP, a[10:8], 1'b0});
      sendb(a[7:0]);
      for (k = 0; k < n; k = k + 1)
         sendb(b + k[7:0]);
      i_mst.stop();
      repeat (2) @(posedge clk);
      #1;
      chk("busy", {7'h0, e}, {7'h0, busy});
      wp = pw;
      for (k = 0; k < 9 && (k == 0 || rx[0] !== 1'b0); k = k + 1)
      begin
         i_mst.start();
         i_mst.xfer({TYP, 4'h0, 1'b1}, rx);
         i_mst.stop();
      end
      chk("poll", {6'h0, e, 1'b0}, {6'h0, k > 1, rx[0]});
   endtask
   // random read behind a dummy write, or current read; nack on the last
   task rd(input [10:0] a, input c, input integer n);
      integer k;
      i_mst.start();
      if (!c)
      begin
         sendb({TYP, a[10:8], 1'b0});
         sendb(a[7:0]);
         i_mst.start();
      end
      sendb({TYP, c ? a[10:8] : 3'h7, 1'b1});
      for (k = 0; k < n; k = k + 1)
      begin
         i_mst.xfer({8'hff, k == n - 1}, rx);
         got[k] = rx[8:1];
      end
      i_mst.stop();
   endtask
   task conclude;
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard, far above the ten thousand cycles expected
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 30000)
      begin
         error_cnt = error_cnt + 1;
         conclude;
      end
   end
   initial
   begin
      rst_b = 1'b0;
      wp = 1'b0;
      error_cnt = 0;
      checked = 0;
      cyc = 0;
      rows = '{19'h00ea0, 19'h00fa1, 19'h010ff, 19'h000a2, 19'h5a35c, 19'h5a4ff};
      repeat (2) @(posedge clk);
      chk("reset", 8'h0, {6'h0, oe, busy});
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rd(11'h000, 1'b1, 1);
      chk("erased", 8'hff, got[0]);
      wr(11'h00e, 8'ha0, 4, 1'b1, 1'b0);
      wr(11'h5a3, 8'h5c, 1, 1'b1, 1'b1);
      wr(11'h5a4, 8'h77, 1, 1'b0, 1'b0);
      wr(11'h123, 8'h00, 0, 1'b0, 1'b0);
      i_mst.start();
      i_mst.xfer({TYP ^ 4'h3, 4'h0, 1'b1}, rx);
      i_mst.stop();
      chk("nack", 8'h1, {7'h0, rx[0]});
      // read-back table
      for (i = 0; i < 6; i = i + 1)
      begin
         rd(rows[i][18:8], 1'b0, 1);
         chk("data", rows[i][7:0], got[0]);
      end
      rd(11'h7ff, 1'b0, 2);
      chk("wrap", 8'ha2, got[1]);
      rd(11'h001, 1'b1, 1);
      chk("current", 8'ha3, got[0]);
      conclude;
   end
endmodule
